// ---- shared/gpp_params.svh ----
`ifndef GPP_PARAMS_SVH
`define GPP_PARAMS_SVH
// Register locations inside the port's I/O window.
`define GPP_ADDR_PIN  2'h0
`define GPP_ADDR_DIR  2'h1
`define GPP_ADDR_OUT  2'h2
// Reset values of the writable registers.
`define GPP_DIR_RST   8'h00
`define GPP_OUT_RST   8'h00
// Port width.
`define GPP_WIDTH     8
`endif

// ---- shared/gpp_pkg.sv ----
`default_nettype none
package gpp_pkg;
  typedef logic [7:0] gpp_byte_t;
  typedef enum logic [1:0] {
    GPP_OP_NONE,
    GPP_OP_BYTE,
    GPP_OP_SETBIT,
    GPP_OP_CLRBIT
  } gpp_op_t;
endpackage
`default_nettype wire

// ---- shared/gpp_sync_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// Carries one port's pin levels into the synchroniser and the result back.
interface gpp_sync_if;
  logic [7:0] pin_level;
  logic [7:0] wr_force;
  logic [7:0] wr_value;
  logic [7:0] pin_input;
  modport ctrl (output pin_level, output wr_force, output wr_value, input pin_input);
  modport sync (input pin_level, input wr_force, input wr_value, output pin_input);
endinterface
`default_nettype wire

// ---- hdl/gpp_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "gpp_params.svh"
// Latch-plus-register synchroniser for one port.
module gpp_sync (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Port side.
  gpp_sync_if.sync  sif
);
  // ****************************************************************
  // Front stage
  // ****************************************************************
  // The front stage is modelled as a negedge flop: same effect as a latch
  // open while the clock is high, but it keeps static timing clean.
  logic [7:0] latch_q;
  logic [7:0] pin_q;
  logic [7:0] latch_d;
  // The front stage takes only the pad level; a software write is forced in at the second stage.
  assign latch_d = sif.pin_level;
  always_ff @(negedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= 8'h00;
    end else begin
      latch_q <= latch_d;
    end
  end
  // Second stage loads the captured value on the next rising edge.
  // A written pin is taken straight from the write value, one period late.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_q <= 8'h00;
    end else begin
      pin_q <= (latch_q & ~sif.wr_force) | (sif.wr_value & sif.wr_force);
    end
  end
  assign sif.pin_input = pin_q;
endmodule
`default_nettype wire

// ---- hdl/gpp_port.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "gpp_params.svh"
// ****************************************************************
// General-purpose I/O port
// ****************************************************************
module gpp_port (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // I/O register access.
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [1:0] io_addr,
  input  wire gpp_pkg::gpp_op_t io_op,
  input  wire logic [2:0] io_bit,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  // Global pull-up disable from the special function control register.
  input  wire logic       global_pullup_disable,
  // Pins.
  input  wire logic [7:0] pad_in,
  output logic      [7:0] pad_out,
  output logic      [7:0] pad_oe,
  output logic      [7:0] pad_pullup
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  gpp_pkg::gpp_byte_t port_direction_q;
  gpp_pkg::gpp_byte_t port_output_value_q;
  gpp_pkg::gpp_byte_t port_direction_d;
  gpp_pkg::gpp_byte_t port_output_value_d;
  logic [7:0] rdata_q;
  logic [7:0] out_q;
  logic [7:0] oe_q;
  logic [7:0] pu_q;
  logic [7:0] wr_force_q;
  logic [7:0] wr_value_q;

  // Decode of the access.
  logic [7:0] bit_mask;
  logic       sel_dir;
  logic       sel_out;
  logic       sel_pin;
  logic [7:0] sel_rdata;
  gpp_sync_if sif ();

  assign bit_mask = 8'h01 << io_bit;
  assign sel_dir  = io_addr == `GPP_ADDR_DIR;
  assign sel_out  = io_addr == `GPP_ADDR_OUT;
  assign sel_pin  = io_addr == `GPP_ADDR_PIN;

  // Next register values; bit operations leave every other pin alone.
  function automatic logic [7:0] upd(input logic [7:0] cur, input gpp_pkg::gpp_op_t op,
                                      input logic [7:0] wd, input logic [7:0] m);
    case (op)
      gpp_pkg::GPP_OP_BYTE:   upd = wd;
      gpp_pkg::GPP_OP_SETBIT: upd = cur | m;
      gpp_pkg::GPP_OP_CLRBIT: upd = cur & ~m;
      default:                upd = cur;
    endcase
  endfunction
  assign port_direction_d    = (io_wr && sel_dir) ?
                               upd(port_direction_q, io_op, io_wdata, bit_mask) : port_direction_q;
  assign port_output_value_d = (io_wr && sel_out) ?
                               upd(port_output_value_q, io_op, io_wdata, bit_mask)
                               : port_output_value_q;

  // Pin input register is read-only; writes to it are dropped.
  assign sel_rdata = sel_dir ? port_direction_q :
                     sel_out ? port_output_value_q :
                     sel_pin ? sif.pin_input : 8'h00;

  // Register storage.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_direction_q    <= `GPP_DIR_RST;
      port_output_value_q <= `GPP_OUT_RST;
      rdata_q             <= 8'h00;
    end else begin
      port_direction_q    <= port_direction_d;
      port_output_value_q <= port_output_value_d;
      if (io_rd) begin
        rdata_q <= sel_rdata;
      end
    end
  end
  assign io_rdata = rdata_q;

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // The drivers follow the next register values so that the pad changes
  // at the edge of the write. Reset clears them asynchronously, so the
  // pins float even with no clock running. Pins are independent bits.
  logic [7:0] pu_d;
  assign pu_d = ~port_direction_d & port_output_value_d
                & {8{~global_pullup_disable}};
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_q  <= 8'h00;
      out_q <= 8'h00;
      pu_q  <= 8'h00;
    end else begin
      oe_q  <= port_direction_d;
      out_q <= port_output_value_d;
      pu_q  <= pu_d;
    end
  end
  assign pad_oe     = oe_q;
  assign pad_out    = out_q;
  assign pad_pullup = pu_q;

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  // Driven pins read back the written value; others read the pad. The pad
  // enters only the front stage of the synchroniser.
  logic [7:0] wr_force_d;
  assign wr_force_d = (io_wr && sel_out) ? port_direction_d : 8'h00;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_force_q <= 8'h00;
      wr_value_q <= 8'h00;
    end else begin
      wr_force_q <= wr_force_d;
      wr_value_q <= port_output_value_d;
    end
  end
  assign sif.pin_level = pad_in;
  assign sif.wr_force  = wr_force_q;
  assign sif.wr_value  = wr_value_q;

  gpp_sync u_sync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .sif     (sif)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Most checks start from a bus write; the drive and pull-up ones judge the pins against
  // what software asked for, while the bit, pin-input and readback ones check internal registers.
  a_pullup_forbid: assert property (@(posedge sys_clk) disable iff (!rst_b)
    global_pullup_disable |=> pad_pullup == 8'h00)
    else $error("Pull-up active while disabled.");
  a_dir_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
    io_wr && sel_dir && io_op == gpp_pkg::GPP_OP_BYTE |=> pad_oe == $past(io_wdata))
    else $error("Driver enable does not follow direction.");
  a_pullup_rule: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ##1 pad_pullup == (~port_direction_q & port_output_value_q
    & {8{~$past(global_pullup_disable)}}))
    else $error("Pull-up mismatch.");
  a_pullup_out_off: assert property (@(posedge sys_clk) disable iff (!rst_b)
    io_wr && sel_dir && io_op == gpp_pkg::GPP_OP_SETBIT
    |=> (pad_pullup & $past(bit_mask)) == 8'h00)
    else $error("Pull-up left on a pin turned to output.");
  a_no_pu_out: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (pad_pullup & pad_oe) == 8'h00)
    else $error("Pull-up on driven pin.");
  a_out_value: assert property (@(posedge sys_clk) disable iff (!rst_b)
    io_wr && sel_out && io_op == gpp_pkg::GPP_OP_BYTE
    |=> (pad_out & pad_oe) == ($past(io_wdata) & pad_oe))
    else $error("Drive level wrong.");
  a_reset_float: assert property (@(posedge sys_clk)
    !rst_b |-> pad_oe == 8'h00 && pad_pullup == 8'h00)
    else $error("Pin not floating in reset.");
  a_bit_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
    io_wr && io_op == gpp_pkg::GPP_OP_SETBIT && sel_dir
    |=> (port_direction_q & ~$past(bit_mask)) == ($past(port_direction_q) & ~$past(bit_mask))
    && (port_direction_q & $past(bit_mask)) != 8'h00)
    else $error("Bit set disturbed other pins.");
  a_clr_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
    io_wr && io_op == gpp_pkg::GPP_OP_CLRBIT && sel_dir
    |=> (port_direction_q & ~$past(bit_mask)) == ($past(port_direction_q) & ~$past(bit_mask))
    && (port_direction_q & $past(bit_mask)) == 8'h00)
    else $error("Bit clear disturbed other pins.");
  a_pin_ro: assert property (@(posedge sys_clk) disable iff (!rst_b)
    io_wr && sel_pin |=> port_direction_q == $past(port_direction_q)
    && port_output_value_q == $past(port_output_value_q))
    else $error("Write to the pin input register changed a register.");
  // Read data is registered and holds until the next read strobe.
  a_rd_data: assert property (@(posedge sys_clk) disable iff (!rst_b)
    io_rd && sel_out |=> io_rdata == $past(port_output_value_q))
    else $error("Read data does not match the output value register.");
  a_rdata_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !io_rd |=> $stable(io_rdata))
    else $error("Read data changed without a read.");
  // A driven pin returns the written byte at the second edge after the write.
  a_wr_readback: assert property (@(posedge sys_clk) disable iff (!rst_b)
    io_wr && sel_out && io_op == gpp_pkg::GPP_OP_BYTE && port_direction_d == 8'hff
    |=> ##1 sif.pin_input == $past(io_wdata, 2))
    else $error("Written value not read back after one period.");
  // Main scenarios that the tests are expected to reach.
  c_bit_set:   cover property (@(posedge sys_clk) io_wr && io_op == gpp_pkg::GPP_OP_SETBIT);
  c_pullup_on: cover property (@(posedge sys_clk) pad_pullup != 8'h00);
  c_readback:  cover property (@(posedge sys_clk) io_rd && sel_pin);
  c_pu_blocked: cover property (@(posedge sys_clk) global_pullup_disable
    && (port_output_value_q & ~port_direction_q) != 8'h00);
  c_rd_after_wr: cover property (@(posedge sys_clk) io_wr && sel_out ##2 io_rd && sel_pin);
endmodule
`default_nettype wire

// ---- dv/gpp_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// External circuitry on the port pins
// ****************************************************************
module gpp_pin_model (
  // Clock.
  input  wire logic       sys_clk,
  // Pin controls from the port.
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup,
  // External drivers.
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // Resolved pin level.
  output logic      [7:0] pad_in
);
  logic [7:0] float_q = 8'h5a;

  // A floating pin wanders every cycle, so a stale level never passes for a read.
  always_ff @(posedge sys_clk) begin
    float_q <= ~float_q;
  end

  // Port drive wins, then the external driver, then the pull-up.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & (pad_pullup | float_q));
endmodule
`default_nettype wire

// ---- dv/gpp_port_pin_control_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "gpp_params.svh"
module gpp_port_pin_control_bench;
  logic             sys_clk = 1'b0;
  logic             rst_b = 1'b1;
  logic             io_wr = 1'b0;
  logic             io_rd = 1'b0;
  logic [1:0]       io_addr = 2'h0;
  gpp_pkg::gpp_op_t io_op = gpp_pkg::GPP_OP_NONE;
  logic [2:0]       io_bit = 3'h0;
  logic [7:0]       io_wdata = 8'h00;
  logic             pu_off = 1'b0;
  logic [7:0]       ext_en = 8'h00;
  logic [7:0]       ext_val = 8'h00;
  logic [7:0]       io_rdata, pad_in, pad_out, pad_oe, pad_pullup;
  int               n_errors = 0;
  int               compares = 0;

  // Clock of 20 ns period.
  always #10 sys_clk = ~sys_clk;

  gpp_port dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .io_op(io_op), .io_bit(io_bit), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .global_pullup_disable(pu_off), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup));
  gpp_pin_model pins_u (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  // ****************************************************************
  // Access and compare tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One write, held over exactly one taking edge.
  task automatic wr(input logic [1:0] a, input gpp_pkg::gpp_op_t op,
                    input logic [2:0] b, input logic [7:0] d);
    @(posedge sys_clk);
    io_wr <= 1'b1;
    io_addr <= a;
    io_op <= op;
    io_bit <= b;
    io_wdata <= d;
    @(posedge sys_clk);
    io_wr <= 1'b0;
    #1;
  endtask

  // Read a register and compare it once the data has landed.
  task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    io_rd <= 1'b1;
    io_addr <= a;
    @(posedge sys_clk);
    io_rd <= 1'b0;
    #1;
    chk(io_rdata, exp);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rchk(`GPP_ADDR_DIR, 8'h00);
    rchk(`GPP_ADDR_OUT, 8'h00);
    chk(pad_oe | pad_pullup, 8'h00);
  endtask

  // Walk every direction, value and disable combination; direction is written
  // first so each move passes through a legal intermediate state.
  task automatic t_table;
    logic d, v, p;
    for (int i = 0; i < 8; i++) begin
      {d, v, p} = i[2:0];
      wr(`GPP_ADDR_DIR, gpp_pkg::GPP_OP_BYTE, 3'h0, {8{d}});
      wr(`GPP_ADDR_OUT, gpp_pkg::GPP_OP_BYTE, 3'h0, {8{v}});
      @(posedge sys_clk);
      pu_off <= p;
      // The pull-up output is registered, so it shows a new disable one edge later.
      @(posedge sys_clk);
      #1;
      chk(pad_oe, {8{d}});
      chk(pad_pullup, {8{~d & v & ~p}});
      if (d) chk(pad_out, {8{v}});
      rchk(`GPP_ADDR_DIR, {8{d}});
      rchk(`GPP_ADDR_OUT, {8{v}});
    end
  endtask

  // Reset in mid-run must float the pins before any further edge.
  task automatic t_async;
    @(posedge sys_clk);
    rst_b <= 1'b0;
    pu_off <= 1'b0;
    #1;
    chk(pad_oe | pad_pullup, 8'h00);
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    rchk(`GPP_ADDR_DIR, 8'h00);
  endtask

  task automatic t_bits;
    wr(`GPP_ADDR_DIR, gpp_pkg::GPP_OP_SETBIT, 3'h3, 8'h00);
    chk(pad_oe, 8'h08);
    wr(`GPP_ADDR_DIR, gpp_pkg::GPP_OP_SETBIT, 3'h7, 8'h00);
    wr(`GPP_ADDR_OUT, gpp_pkg::GPP_OP_SETBIT, 3'h7, 8'h00);
    wr(`GPP_ADDR_OUT, gpp_pkg::GPP_OP_SETBIT, 3'h0, 8'h00);
    chk(pad_out & pad_oe, 8'h80);
    chk(pad_pullup, 8'h01);
    wr(`GPP_ADDR_DIR, gpp_pkg::GPP_OP_CLRBIT, 3'h3, 8'h00);
    chk(pad_oe, 8'h80);
  endtask

  // Writes to the read-only and unmapped places, and a write with no op.
  task automatic t_refuse;
    wr(`GPP_ADDR_PIN, gpp_pkg::GPP_OP_BYTE, 3'h0, 8'hff);
    wr(2'h3, gpp_pkg::GPP_OP_BYTE, 3'h0, 8'hff);
    wr(`GPP_ADDR_OUT, gpp_pkg::GPP_OP_NONE, 3'h0, 8'hff);
    rchk(2'h3, 8'h00);
    rchk(`GPP_ADDR_DIR, 8'h80);
    rchk(`GPP_ADDR_OUT, 8'h81);
  endtask

  // Pin reads: driven, pulled up and externally driven bits together.
  task automatic t_pins;
    @(posedge sys_clk);
    ext_en <= 8'h7e;
    ext_val <= 8'h24;
    wr(`GPP_ADDR_OUT, gpp_pkg::GPP_OP_BYTE, 3'h0, 8'h01);
    rchk(`GPP_ADDR_PIN, 8'h25);
    @(posedge sys_clk);
    ext_val <= 8'h5a;
    #1;
    rchk(`GPP_ADDR_PIN, 8'h5b);
    // A pin change at a rising edge misses that edge and lands one period later.
    @(posedge sys_clk);
    ext_val <= 8'h24;
    io_rd <= 1'b1;
    io_addr <= `GPP_ADDR_PIN;
    @(posedge sys_clk);
    #1;
    chk(io_rdata, 8'h5b);
    @(posedge sys_clk);
    io_rd <= 1'b0;
    #1;
    chk(io_rdata, 8'h25);
  endtask

  task automatic wrap_up;
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence after three cycles of reset. Reset falls at time zero by a
  // non-blocking write, so the asynchronous reset branches see a real edge.
  initial begin
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_table();
    t_async();
    t_bits();
    t_refuse();
    t_pins();
    wrap_up();
  end

  // The tests need well under a thousand cycles; ten thousand means a hang.
  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
